/* File: iaf_regs.sv */
// Receive filter registers and quadlet data ports behind the host register port
`timescale 1ns/1ns
`include "iaf_consts.svh"
module iaf_regs
	import iaf_pkg::*;
(
	// Clock and reset
	input wire logic core_clk_in,
	input wire logic rst_in,
	// Host register port pins
	input wire logic host_cs_n_in,
	input wire logic host_rd_n_in,
	input wire logic host_wr_n_in,
	input wire logic [6:0] host_addr_in,
	input wire logic [31:0] host_data_in,
	output logic [31:0] host_data_out,
	output logic host_data_oe_out,
	// Packet engine side
	input wire logic iso_dest_rxbuf_in,
	input wire iaf_ctime_t cycle_timer_in,
	input wire logic iso_pkt_valid_in,
	input wire logic stream_pkt_valid_in,
	input wire iaf_hdr_t pkt_hdr_in,
	output logic iso_accept_out,
	output logic stream_accept_out,
	// Error reports
	input wire logic err_valid_in,
	input wire logic [1:0] err_cause_in,
	input wire iaf_hdr_t err_hdr_in,
	// Buffers
	output logic async_transmit_push_out,
	output logic iso_transmit_push_out,
	output logic [31:0] transmit_word_out,
	input wire logic async_receive_valid_in,
	input wire logic [31:0] async_receive_word_in,
	output logic async_receive_pop_out,
	input wire logic iso_receive_valid_in,
	input wire logic [31:0] iso_receive_word_in,
	output logic iso_receive_pop_out
);
	// ----------------------------------------
	// Host pin synchroniser
	// ----------------------------------------
	// Address and data ride with the strobes so all three stages stay aligned
	logic [41:0] pin_s1_q;
	logic [41:0] pin_s2_q;
	logic [41:0] pin_s3_q;
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			pin_s1_q <= {3'h7, 39'h0};
			pin_s2_q <= {3'h7, 39'h0};
			pin_s3_q <= {3'h7, 39'h0};
		end else begin
			pin_s1_q <= {host_cs_n_in, host_rd_n_in, host_wr_n_in, host_addr_in, host_data_in};
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
		end
	end
	wire rd_now = !pin_s2_q[41] && !pin_s2_q[40];
	wire rd_was = !pin_s3_q[41] && !pin_s3_q[40];
	wire rd_start = rd_now && !rd_was;
	// Write taken at the end of the strobe, when data has settled longest
	wire wr_end = !pin_s3_q[41] && !pin_s3_q[39] && pin_s2_q[39];
	wire [6:0] rd_addr = pin_s2_q[38:32];
	wire [6:0] wr_addr = pin_s3_q[38:32];
	wire [31:0] wr_data = pin_s3_q[31:0];

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	logic [31:0] cfg_q;
	logic [31:0] match_one_q;
	logic [31:0] match_two_q;
	logic [31:0] err_q;
	logic [31:0] stream_q;
	logic [31:0] atx_last_q;
	logic [31:0] itx_last_q;
	wire wr_cfg = wr_end && wr_addr == `IAF_OFS_HOST_CFG;
	wire wr_m1 = wr_end && wr_addr == `IAF_OFS_MATCH_ONE;
	wire wr_m2 = wr_end && wr_addr == `IAF_OFS_MATCH_TWO;
	wire wr_strm = wr_end && wr_addr == `IAF_OFS_STREAM;
	wire wr_atx = wr_end && wr_addr == `IAF_OFS_ATX;
	wire wr_itx = wr_end && wr_addr == `IAF_OFS_ITX;
	wire rd_arx = rd_start && rd_addr == `IAF_OFS_ARX;
	wire rd_irx = rd_start && rd_addr == `IAF_OFS_IRX;
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			cfg_q <= `IAF_RST_WORD;
			match_one_q <= `IAF_RST_WORD;
			match_two_q <= `IAF_RST_WORD;
			stream_q <= `IAF_RST_WORD;
			atx_last_q <= `IAF_RST_WORD;
			itx_last_q <= `IAF_RST_WORD;
		end else begin
			if (wr_cfg) cfg_q <= wr_data & `IAF_CFG_MASK;
			if (wr_m1) match_one_q <= wr_data & `IAF_MATCH_MASK;
			if (wr_m2) match_two_q <= wr_data & `IAF_MATCH_MASK;
			if (wr_strm) stream_q <= wr_data & `IAF_STREAM_MASK;
			if (wr_atx) atx_last_q <= wr_data;
			if (wr_itx) itx_last_q <= wr_data;
		end
	end
	wire sync_gate = cfg_q[`IAF_CFG_SYNC_GATING_ENABLE];
	wire rx_en = cfg_q[`IAF_CFG_RXEN];
	wire [1:0] tsel = cfg_q[`IAF_CFG_TSEL +: 2];
	wire [3:0] stop_sync_value = cfg_q[`IAF_CFG_STOP +: 4];
	wire [3:0] start_sync_value = cfg_q[`IAF_CFG_START +: 4];
	wire [5:0] chan_filter = cfg_q[`IAF_CFG_CHAN +: 6];
	wire [1:0] tag_filter = cfg_q[`IAF_CFG_TAG +: 2];

	// ----------------------------------------
	// Read mux and buffer strobes
	// ----------------------------------------
	logic [31:0] rd_mux;
	always_comb begin
		case (rd_addr)
			`IAF_OFS_HOST_CFG: rd_mux = cfg_q;
			`IAF_OFS_MATCH_ONE: rd_mux = match_one_q;
			`IAF_OFS_MATCH_TWO: rd_mux = match_two_q;
			`IAF_OFS_ERR: rd_mux = err_q;
			`IAF_OFS_STREAM: rd_mux = stream_q;
			`IAF_OFS_ATX: rd_mux = atx_last_q;
			`IAF_OFS_ARX: rd_mux = async_receive_valid_in ? async_receive_word_in : 32'h0;
			`IAF_OFS_ITX: rd_mux = itx_last_q;
			`IAF_OFS_IRX: rd_mux = iso_receive_valid_in ? iso_receive_word_in : 32'h0;
			default: rd_mux = 32'h0;
		endcase
	end
	logic [31:0] rdata_q;
	logic atx_push_q;
	logic itx_push_q;
	logic [31:0] tx_word_q;
	logic arx_pop_q;
	logic irx_pop_q;
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			rdata_q <= 32'h0;
			atx_push_q <= 1'b0;
			itx_push_q <= 1'b0;
			tx_word_q <= 32'h0;
			arx_pop_q <= 1'b0;
			irx_pop_q <= 1'b0;
		end else begin
			if (rd_start) rdata_q <= rd_mux;
			atx_push_q <= wr_atx;
			itx_push_q <= wr_itx;
			if (wr_atx || wr_itx) tx_word_q <= wr_data;
			arx_pop_q <= rd_arx && async_receive_valid_in;
			irx_pop_q <= rd_irx && iso_receive_valid_in;
		end
	end
	assign host_data_out = rdata_q;
	// Output enable waits one cycle after the strobe so the bus never shows stale data
	logic oe_q;
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) oe_q <= 1'b0;
		else oe_q <= rd_now;
	end
	assign host_data_oe_out = oe_q && rd_now;
	assign async_transmit_push_out = atx_push_q;
	assign iso_transmit_push_out = itx_push_q;
	assign transmit_word_out = tx_word_q;
	assign async_receive_pop_out = arx_pop_q;
	assign iso_receive_pop_out = irx_pop_q;

	// ----------------------------------------
	// Cycle timer start
	// ----------------------------------------
	wire ct_valid = cycle_timer_in.cnt < `IAF_CYC_MODULO;
	wire hit_one = ct_valid && cycle_timer_in.cnt == match_one_q[`IAF_CT_CNT +: 13]
		&& cycle_timer_in.secs == match_one_q[`IAF_CT_SECS +: 7];
	wire hit_two = ct_valid && cycle_timer_in.cnt == match_two_q[`IAF_CT_CNT +: 13]
		&& cycle_timer_in.secs == match_two_q[`IAF_CT_SECS +: 7];
	wire rx_live = rx_en && iso_dest_rxbuf_in;
	// Reserved code never matches, so reception stays held off unless timer_go_q was already set before the switch
	wire sel_hit = (tsel == IAF_TS_ONE && hit_one) || (tsel == IAF_TS_TWO && hit_two);
	logic timer_go_q;
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) timer_go_q <= 1'b0;
		else if (!rx_live || tsel == IAF_TS_OFF) timer_go_q <= 1'b0;
		else if (sel_hit) timer_go_q <= 1'b1;
	end
	wire timer_ok = tsel == IAF_TS_OFF || timer_go_q;

	// ----------------------------------------
	// Isochronous acceptance
	// ----------------------------------------
	wire tc_hit = iso_pkt_valid_in && pkt_hdr_in.tag == tag_filter
		&& pkt_hdr_in.chan == chan_filter;
	wire is_start = tc_hit && pkt_hdr_in.sync == start_sync_value;
	wire is_stop = tc_hit && pkt_hdr_in.sync == stop_sync_value;
	iaf_state_t state_q;
	iaf_state_t state_d;
	always_comb begin
		state_d = state_q;
		case (state_q)
			IAF_WAIT: if (rx_live && timer_ok && sync_gate && is_start) state_d = IAF_RUN;
			IAF_RUN: if (is_stop) state_d = IAF_WAIT;
			default: state_d = IAF_WAIT;
		endcase
		if (!rx_live || !sync_gate) state_d = IAF_WAIT;
	end
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) state_q <= IAF_WAIT;
		else state_q <= state_d;
	end
	wire gate_open = !sync_gate || (state_q == IAF_RUN && !is_stop)
		|| (state_q == IAF_WAIT && is_start);
	wire iso_take = rx_live && timer_ok && tc_hit && gate_open;

	// ----------------------------------------
	// Stream filters
	// ----------------------------------------
	wire sf1 = stream_q[`IAF_SF1_EN] && pkt_hdr_in.chan == stream_q[`IAF_SF1_CHAN +: 6]
		&& pkt_hdr_in.tag == stream_q[`IAF_SF1_TAG +: 2];
	wire sf2 = stream_q[`IAF_SF2_EN] && pkt_hdr_in.chan == stream_q[`IAF_SF2_CHAN +: 6]
		&& pkt_hdr_in.tag == stream_q[`IAF_SF2_TAG +: 2];
	wire strm_take = stream_pkt_valid_in && (sf1 || sf2);
	logic iso_acc_q;
	logic strm_acc_q;
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			iso_acc_q <= 1'b0;
			strm_acc_q <= 1'b0;
		end else begin
			iso_acc_q <= iso_take;
			strm_acc_q <= strm_take;
		end
	end
	assign iso_accept_out = iso_acc_q;
	assign stream_accept_out = strm_acc_q;

	// ----------------------------------------
	// Error capture
	// ----------------------------------------
	// Buffer-full reports only count while the receive buffer is the target
	wire err_take = err_valid_in && (err_cause_in != 2'h3 || iso_dest_rxbuf_in);
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) err_q <= `IAF_RST_WORD;
		else if (err_take) err_q <= {cycle_timer_in.secs, cycle_timer_in.cnt, err_cause_in,
			err_hdr_in.speed, err_hdr_in.tag, err_hdr_in.chan};
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (rst_in);
	rx_gate_a: assert property (iso_accept_out |-> $past(rx_en) && $past(iso_dest_rxbuf_in))
		else $error("accept without enable or buffer select");
	tag_chan_a: assert property (iso_accept_out |-> $past(pkt_hdr_in.tag) == $past(tag_filter)
		&& $past(pkt_hdr_in.chan) == $past(chan_filter))
		else $error("accept with wrong tag or channel");
	no_gate_a: assert property (iso_pkt_valid_in && rx_live && !sync_gate && timer_ok
		&& pkt_hdr_in.tag == tag_filter && pkt_hdr_in.chan == chan_filter
		|=> iso_accept_out)
		else $error("ungated packet refused");
	start_run_a: assert property (state_q == IAF_WAIT && rx_live && timer_ok && sync_gate
		&& is_start |=> state_q == IAF_RUN && iso_accept_out)
		else $error("start sync did not open");
	stop_run_a: assert property (state_q == IAF_RUN && is_stop
		|=> state_q == IAF_WAIT && !iso_accept_out)
		else $error("stop sync did not close");
	rx_off_a: assert property ($fell(rx_en) |=> state_q == IAF_WAIT ##1 state_q == IAF_WAIT)
		else $error("run survived enable clear");
	timer_sel_a: assert property (rx_live && tsel == IAF_TS_TWO && hit_two |=> timer_go_q)
		else $error("second match did not start");
	timer_off_a: assert property (tsel == IAF_TS_OFF |=> !timer_go_q)
		else $error("timer start while off");
	err_hold_a: assert property (!err_take |=> $stable(err_q))
		else $error("error register changed without error");
	err_take_a: assert property (err_take |=> err_q[5:0] == $past(err_hdr_in.chan)
		&& err_q[11:10] == $past(err_cause_in) && err_q[24:12] == $past(cycle_timer_in.cnt))
		else $error("error fields not captured");
	atx_push_a: assert property (wr_atx |=> async_transmit_push_out
		&& transmit_word_out == $past(wr_data) && atx_last_q == $past(wr_data))
		else $error("transmit write not pushed");
	arx_pop_a: assert property (rd_arx && async_receive_valid_in |=> async_receive_pop_out
		&& host_data_out == $past(async_receive_word_in))
		else $error("receive read did not pop");
	sync_run_c: cover property (state_q == IAF_WAIT ##1 state_q == IAF_RUN ##[1:50] state_q == IAF_WAIT);
	err_cap_c: cover property (err_take ##[1:50] err_take);
	timer_go_c: cover property ($rose(timer_go_q) ##[1:20] iso_accept_out);
	stream_c: cover property (stream_accept_out);
endmodule

/* File: iaf_consts.svh */
// Offsets, field positions, reset values and masks of the receive filter registers
`ifndef IAF_CONSTS_SVH
`define IAF_CONSTS_SVH
`define IAF_OFS_HOST_CFG 7'h40
`define IAF_OFS_MATCH_ONE 7'h44
`define IAF_OFS_MATCH_TWO 7'h48
`define IAF_OFS_ERR 7'h4C
`define IAF_OFS_STREAM 7'h50
`define IAF_OFS_ATX 7'h54
`define IAF_OFS_ARX 7'h58
`define IAF_OFS_ITX 7'h5C
`define IAF_OFS_IRX 7'h60
`define IAF_RST_WORD 32'h00000000
`define IAF_CFG_MASK 32'hFF000FFF
`define IAF_MATCH_MASK 32'hFFFFF000
`define IAF_STREAM_MASK 32'h80FF80FF
`define IAF_CFG_SYNC_GATING_ENABLE 0
`define IAF_CFG_RXEN 1
`define IAF_CFG_TSEL 2
`define IAF_CFG_STOP 4
`define IAF_CFG_START 8
`define IAF_CFG_CHAN 24
`define IAF_CFG_TAG 30
`define IAF_CT_CNT 12
`define IAF_CT_SECS 25
`define IAF_CYC_MODULO 13'h1F40
`define IAF_SF2_CHAN 0
`define IAF_SF2_TAG 6
`define IAF_SF2_EN 15
`define IAF_SF1_CHAN 16
`define IAF_SF1_TAG 22
`define IAF_SF1_EN 31
`endif

/* File: iaf_pkg.sv */
// Types shared by the receive filter register bank
package iaf_pkg;
	typedef struct packed {
		logic [1:0] tag;
		logic [5:0] chan;
		logic [3:0] sync;
		logic [1:0] speed;
	} iaf_hdr_t;
	typedef struct packed {
		logic [6:0] secs;
		logic [12:0] cnt;
	} iaf_ctime_t;
	typedef enum logic [1:0] {
		IAF_TS_OFF = 2'b00,
		IAF_TS_ONE = 2'b01,
		IAF_TS_TWO = 2'b10,
		IAF_TS_RSV = 2'b11
	} iaf_tsel_t;
	typedef enum logic [1:0] {
		IAF_WAIT = 2'b01,
		IAF_RUN = 2'b10
	} iaf_state_t;
endpackage

/* File: iaf_host_model.sv */
// Host processor model driving the register port pins
`timescale 1ns/1ns
module iaf_host_model (
	// Clock
	input wire logic clk_in,
	// Register port pins
	output logic cs_n_out,
	output logic rd_n_out,
	output logic wr_n_out,
	output logic [6:0] addr_out,
	output logic [31:0] data_out,
	input wire logic [31:0] rdata_in
);
	initial begin
		cs_n_out = 1'b1;
		rd_n_out = 1'b1;
		wr_n_out = 1'b1;
		addr_out = 7'h00;
		data_out = 32'h00000000;
	end
	// Full quadlet write, data held past the strobe rise
	task automatic write_word(input logic [6:0] a, input logic [31:0] d);
		@(negedge clk_in);
		addr_out = a;
		data_out = d;
		cs_n_out = 1'b0;
		wr_n_out = 1'b0;
		repeat (4) @(negedge clk_in);
		wr_n_out = 1'b1;
		repeat (2) @(negedge clk_in);
		cs_n_out = 1'b1;
		// Released bus shows garbage, never the last value
		data_out = ~d;
		repeat (4) @(negedge clk_in);
	endtask
	// Full quadlet read, sampled after the answer has settled
	task automatic read_word(input logic [6:0] a, output logic [31:0] d);
		@(negedge clk_in);
		addr_out = a;
		cs_n_out = 1'b0;
		rd_n_out = 1'b0;
		repeat (5) @(negedge clk_in);
		d = rdata_in;
		cs_n_out = 1'b1;
		rd_n_out = 1'b1;
		repeat (4) @(negedge clk_in);
	endtask
endmodule

/* File: test_iaf_regs.sv */
// Self-checking testbench of the receive filter register bank
`timescale 1ns/1ns
module test_iaf_regs;
	import iaf_pkg::*;
	logic clk, rst, dest, ipv, spv, ev, arv, irv, oe, iacc, sacc, apush, ipush, apop, ipop;
	logic cs_n, rd_n, wr_n;
	logic [6:0] addr;
	logic [31:0] wdat, rdat, tw, arw, irw, rd, last_tw;
	logic [1:0] ecause;
	iaf_ctime_t ctime;
	iaf_hdr_t hdr, ehdr;
	int n_fail, total_checks, cyc, n_apush, n_ipush, n_apop, n_ipop, n_oe;
	iaf_host_model host (.clk_in(clk), .cs_n_out(cs_n), .rd_n_out(rd_n), .wr_n_out(wr_n),
		.addr_out(addr), .data_out(wdat), .rdata_in(rdat));
	iaf_regs uut (.core_clk_in(clk), .rst_in(rst), .host_cs_n_in(cs_n), .host_rd_n_in(rd_n),
		.host_wr_n_in(wr_n), .host_addr_in(addr), .host_data_in(wdat), .host_data_out(rdat),
		.host_data_oe_out(oe), .iso_dest_rxbuf_in(dest), .cycle_timer_in(ctime),
		.iso_pkt_valid_in(ipv), .stream_pkt_valid_in(spv), .pkt_hdr_in(hdr),
		.iso_accept_out(iacc), .stream_accept_out(sacc), .err_valid_in(ev),
		.err_cause_in(ecause), .err_hdr_in(ehdr), .async_transmit_push_out(apush),
		.iso_transmit_push_out(ipush), .transmit_word_out(tw), .async_receive_valid_in(arv),
		.async_receive_word_in(arw), .async_receive_pop_out(apop), .iso_receive_valid_in(irv),
		.iso_receive_word_in(irw), .iso_receive_pop_out(ipop));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// ----------------------------------------
	// Watchers and helpers
	// ----------------------------------------
	always @(posedge clk) begin
		cyc++;
		if (apush) begin
			n_apush++;
			last_tw = tw;
		end
		if (ipush) begin
			n_ipush++;
			last_tw = tw;
		end
		n_apop += int'(apop);
		n_ipop += int'(ipop);
		n_oe += int'(oe);
		if (cyc == 5000) begin
			n_fail++;
			finish_test();
		end
	end
	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			$display("FAIL %s expected %h seen %h", name, exp, got);
			n_fail++;
		end
	endtask
	task automatic rd_chk(input logic [6:0] a, input logic [31:0] exp);
		host.read_word(a, rd);
		check($sformatf("reg %h", a), exp, rd);
	endtask
	// One packet header; accept looked at in its single cycle
	task automatic pkt(input logic iso, input logic [1:0] t, input logic [5:0] c,
		input logic [3:0] s, input logic exp);
		@(negedge clk);
		hdr = {t, c, s, 2'h0};
		ipv = iso;
		spv = ~iso;
		@(negedge clk);
		ipv = 1'b0;
		spv = 1'b0;
		check(iso ? "iso accept" : "stream accept", {31'h0, exp}, {31'h0, iso ? iacc : sacc});
	endtask
	task automatic err(input logic [1:0] c, input logic d);
		@(negedge clk);
		dest = d;
		ecause = c;
		ev = 1'b1;
		@(negedge clk);
		ev = 1'b0;
		dest = 1'b1;
	endtask
	function automatic logic [31:0] ew(input logic [1:0] c);
		return {ctime.secs, ctime.cnt, c, ehdr.speed, ehdr.tag, ehdr.chan};
	endfunction
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_regs();
		logic [6:0] ofs[8] = '{7'h40, 7'h44, 7'h48, 7'h4C, 7'h50, 7'h54, 7'h5C, 7'h00};
		logic [31:0] wv[5] = '{32'hFFFFFFF3, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF};
		logic [31:0] mv[5] = '{32'hFF000FF3, 32'hFFFFF000, 32'hFFFFF000, 32'h00000000, 32'h80FF80FF};
		foreach (ofs[i]) rd_chk(ofs[i], 32'h00000000);
		// Timer select 11 avoided in the all-ones pattern
		for (int i = 0; i < 5; i++) begin
			host.write_word(ofs[i], wv[i]);
			rd_chk(ofs[i], mv[i]);
			host.write_word(ofs[i], 32'h00000000);
		end
		host.write_word(7'h00, 32'hFFFFFFFF);
		rd_chk(7'h00, 32'h00000000);
		$display("register test done");
	endtask
	task automatic t_iso();
		host.write_word(7'h40, 32'h85000002);
		pkt(1'b1, 2'h2, 6'h05, 4'h0, 1'b1);
		pkt(1'b1, 2'h1, 6'h05, 4'h0, 1'b0);
		pkt(1'b1, 2'h2, 6'h04, 4'h0, 1'b0);
		dest = 1'b0;
		pkt(1'b1, 2'h2, 6'h05, 4'h0, 1'b0);
		dest = 1'b1;
		host.write_word(7'h40, 32'h85000000);
		pkt(1'b1, 2'h2, 6'h05, 4'h0, 1'b0);
		host.write_word(7'h40, 32'h85000393);
		pkt(1'b1, 2'h2, 6'h05, 4'h0, 1'b0);
		pkt(1'b1, 2'h2, 6'h05, 4'h3, 1'b1);
		pkt(1'b1, 2'h2, 6'h05, 4'h0, 1'b1);
		pkt(1'b1, 2'h2, 6'h05, 4'h9, 1'b0);
		pkt(1'b1, 2'h2, 6'h05, 4'h0, 1'b0);
		pkt(1'b1, 2'h2, 6'h05, 4'h3, 1'b1);
		host.write_word(7'h40, 32'h85000391);
		host.write_word(7'h40, 32'h85000393);
		pkt(1'b1, 2'h2, 6'h05, 4'h0, 1'b0);
		$display("iso filter test done");
	endtask
	task automatic t_timer();
		host.write_word(7'h44, 32'h04007000);
		host.write_word(7'h48, 32'h08009000);
		host.write_word(7'h40, 32'h00000006);
		pkt(1'b1, 2'h0, 6'h00, 4'h0, 1'b0);
		ctime = {7'h02, 13'h0007};
		@(negedge clk);
		ctime = '0;
		pkt(1'b1, 2'h0, 6'h00, 4'h0, 1'b1);
		host.write_word(7'h40, 32'h00000000);
		host.write_word(7'h40, 32'h0000000A);
		ctime = {7'h02, 13'h0007};
		pkt(1'b1, 2'h0, 6'h00, 4'h0, 1'b0);
		ctime = {7'h04, 13'h0009};
		@(negedge clk);
		ctime = '0;
		pkt(1'b1, 2'h0, 6'h00, 4'h0, 1'b1);
		host.write_word(7'h40, 32'h00000000);
		// Count 8000 lies outside the cycle range, so it must never match
		host.write_word(7'h44, 32'h05F40000);
		host.write_word(7'h40, 32'h00000006);
		ctime = {7'h02, 13'h1F40};
		@(negedge clk);
		ctime = '0;
		pkt(1'b1, 2'h0, 6'h00, 4'h0, 1'b0);
		host.write_word(7'h40, 32'h00000000);
		$display("timer start test done");
	endtask
	task automatic t_stream();
		host.write_word(7'h50, 32'h80498083);
		pkt(1'b0, 2'h1, 6'h09, 4'h0, 1'b1);
		pkt(1'b0, 2'h1, 6'h08, 4'h0, 1'b0);
		pkt(1'b0, 2'h2, 6'h03, 4'h0, 1'b1);
		host.write_word(7'h50, 32'h00498083);
		pkt(1'b0, 2'h1, 6'h09, 4'h0, 1'b0);
		$display("stream filter test done");
	endtask
	task automatic t_err();
		ctime = {7'h05, 13'h0123};
		ehdr = {2'h1, 6'h2A, 4'h0, 2'h2};
		err(2'h1, 1'b1);
		rd_chk(7'h4C, ew(2'h1));
		ctime = {7'h06, 13'h1F3F};
		err(2'h3, 1'b0);
		rd_chk(7'h4C, {7'h05, 13'h0123, 12'h66A});
		err(2'h3, 1'b1);
		rd_chk(7'h4C, ew(2'h3));
		$display("error capture test done");
	endtask
	task automatic t_data();
		int n0;
		host.write_word(7'h54, 32'hA5C31E0F);
		check("async pushes", 32'h1, n_apush);
		check("pushed word", 32'hA5C31E0F, last_tw);
		rd_chk(7'h54, 32'hA5C31E0F);
		host.write_word(7'h5C, 32'h0F1EC3A5);
		check("iso pushes", 32'h1, n_ipush);
		check("pushed word", 32'h0F1EC3A5, last_tw);
		rd_chk(7'h5C, 32'h0F1EC3A5);
		rd_chk(7'h60, 32'h00000000);
		check("iso pops", 32'h0, n_ipop);
		arv = 1'b1;
		irv = 1'b1;
		n0 = n_oe;
		rd_chk(7'h58, 32'h13579BDF);
		// Drive enable follows the synced strobe, rising on the same edge as the data load
		check("drive enable cycles", 32'h4, n_oe - n0);
		check("async pops", 32'h1, n_apop);
		rd_chk(7'h60, 32'h2468ACE0);
		check("iso pops", 32'h1, n_ipop);
		$display("data port test done");
	endtask
	task automatic finish_test();
		$display("checks %0d failures %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		{dest, ipv, spv, ev, arv, irv} = 6'h20;
		ecause = 2'h0;
		ctime = '0;
		hdr = '0;
		ehdr = '0;
		arw = 32'h13579BDF;
		irw = 32'h2468ACE0;
		rst = 1'b1;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		repeat (3) @(negedge clk);
		t_regs();
		t_iso();
		t_timer();
		t_stream();
		t_err();
		t_data();
		finish_test();
	end
endmodule
